// ==== hw/sound_generator_pkg.sv ====
package sound_generator_pkg;
   // ****************************************
   // Register map (index, byte address = 4 * index)
   // ****************************************
   localparam int NUM_REGS = 16;
   localparam logic [3:0] IDX_A_FINE = 4'h0;
   localparam logic [3:0] IDX_A_COARSE = 4'h1;
   localparam logic [3:0] IDX_B_FINE = 4'h2;
   localparam logic [3:0] IDX_B_COARSE = 4'h3;
   localparam logic [3:0] IDX_C_FINE = 4'h4;
   localparam logic [3:0] IDX_C_COARSE = 4'h5;
   localparam logic [3:0] IDX_NOISE_RATE = 4'h6;
   localparam logic [3:0] IDX_MIXER = 4'h7;
   localparam logic [3:0] IDX_AMP_A = 4'h8;
   localparam logic [3:0] IDX_ENV_FINE = 4'hb;
   localparam logic [3:0] IDX_ENV_COARSE = 4'hc;
   localparam logic [3:0] IDX_ENV_SHAPE = 4'hd;
   localparam logic [7:0] REG_RESET = 8'hff;
   localparam logic [7:0] AMP_RESET = 8'h00;
   localparam logic [7:0] SHAPE_RESET = 8'h00;
   localparam int ADDR_LSB = 2;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int COARSE_W = 4;
   localparam int NOISE_W = 5;
   localparam int NOISE_EN_LSB = 3;
   localparam int AMP_MODE_BIT = 4;
   localparam int LEVEL_W = 4;
   localparam int SHAPE_HOLD = 3;
   localparam int SHAPE_ALT = 2;
   localparam int SHAPE_ATTACK = 1;
   localparam int SHAPE_CONT = 0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int TONE_PRESCALE = 16;
   localparam int ENV_PRESCALE = 256;
   localparam logic [16:0] LFSR_SEED = 17'h00001;
endpackage

// ==== hw/sound_generator.sv ====
//Behaviour
//- Host loads sixteen registers; sound then runs with no further commands.
//- Three channels A, B, C, each with its own tone generator.
//- Tone rate is clock divided by sixteen then by twelve-bit period.
//- Period: coarse bits 3..0 on top, fine byte below; coarse upper ignored.
//- Channel A uses register 0 fine and register 1 coarse.
//- Noise rate is clock divided by sixteen then by register 6 bits 4..0.
//- One pseudo-random noise square wave shared by all three mixers.
//- Register 7 selects tone, noise, both or neither per channel.
//- Registers 8..10 pick fixed level or envelope level per channel.
//- Each converter receives a four-bit level code, sixteen levels.
//- Registers 11..13 set envelope period and shape for modulation.
//- Mixer enables active low: bits 2..0 tone, bits 5..3 noise.
//- Amplitude bit 4 selects envelope, bits 3..0 fixed level.
//- Envelope rate is clock divided by 256 then sixteen-bit period.
//- Four-bit envelope counter, sixteen steps, shape bits set direction and repeat.
`timescale 1ns/10ps
module sound_generator
   import sound_generator_pkg::*;
#(
   parameter int NUM_CH = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [sound_generator_pkg::LEVEL_W-1:0] level_a_q,
   output logic [sound_generator_pkg::LEVEL_W-1:0] level_b_q,
   output logic [sound_generator_pkg::LEVEL_W-1:0] level_c_q
);
   import sound_generator_pkg::*;

   // ****************************************
   // Register bank over APB
   // ****************************************
   logic [7:0] regs_q [NUM_REGS];
   logic [3:0] idx;
   logic mapped;
   logic acc;
   assign idx = paddr[ADDR_LSB +: 4];
   assign mapped = (paddr[11:ADDR_LSB+4] == '0) && (paddr[1:0] == 2'b00);
   assign acc = psel && penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= (i >= int'(IDX_AMP_A)) ? AMP_RESET : REG_RESET;
         end
      end else if (acc && pwrite && mapped) begin
         regs_q[idx] <= pwdata[7:0];
      end
   end

   logic env_restart;
   assign env_restart = acc && pwrite && mapped && (idx == IDX_ENV_SHAPE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && mapped && !pwrite) ? {24'h000000, regs_q[idx]} : '0;
      end
   end

   a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && mapped && !pwrite |=> prdata == {24'h000000, $past(regs_q[idx])})
      else $error("read data not returned");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready longer than one cycle");
   a_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == '0)
      else $error("read data upper bits not zero");
   a_regs_sustain: assert property (@(posedge pclk) disable iff (!presetn)
      !(acc && pwrite) |=> regs_q[IDX_MIXER] == $past(regs_q[IDX_MIXER]))
      else $error("register changed without a write");
   a_unmapped_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
      acc && pwrite && !mapped |=> regs_q[$past(idx)] == $past(regs_q[idx]))
      else $error("unmapped write stored");

   // ****************************************
   // Prescalers
   // ****************************************
   logic [7:0] pre_q;
   logic tick16;
   logic tick_half;
   logic tick256;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_q <= '0;
      else pre_q <= pre_q + 8'h01;
   end
   assign tick16 = (pre_q[3:0] == 4'(TONE_PRESCALE - 1));
   // Double-rate tick (every eight clocks): the square wave toggles twice per tone period
   assign tick_half = (pre_q[2:0] == 3'(TONE_PRESCALE / 2 - 1));
   assign tick256 = (pre_q == 8'(ENV_PRESCALE - 1));

   a_half_tick: assert property (@(posedge pclk) disable iff (!presetn)
      tick_half |=> !tick_half [*7])
      else $error("half tick too frequent");
   a_half_in_16: assert property (@(posedge pclk) disable iff (!presetn)
      tick16 |-> tick_half)
      else $error("half tick not aligned");

   // ****************************************
   // Tone generators
   // ****************************************
   logic [NUM_CH-1:0] tone;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_tone
         logic [11:0] period;
         logic [11:0] cnt_q;
         logic sq_q;
         assign period = {regs_q[2*g+1][COARSE_W-1:0], regs_q[2*g]};
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_q <= '0;
               sq_q <= 1'b0;
            end else if (tick_half) begin
               if (cnt_q + 12'h001 >= period) begin
                  cnt_q <= '0;
                  sq_q <= !sq_q;
               end else begin
                  cnt_q <= cnt_q + 12'h001;
               end
            end
         end
         assign tone[g] = sq_q;
      end
   endgenerate

   a_tone_step: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(g_tone[0].sq_q) |-> $past(tick_half))
      else $error("tone toggled off the half tick");
   a_tone_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !tick_half |=> $stable(g_tone[1].sq_q))
      else $error("tone changed between ticks");
   a_tone_bound: assert property (@(posedge pclk) disable iff (!presetn)
      tick_half |=> g_tone[2].cnt_q < $past(g_tone[2].period) || g_tone[2].cnt_q == '0)
      else $error("tone count beyond period");

   // ****************************************
   // Noise generator
   // ****************************************
   logic [NOISE_W-1:0] ncnt_q;
   logic [16:0] lfsr_q;
   logic [NOISE_W-1:0] nper;
   assign nper = regs_q[IDX_NOISE_RATE][NOISE_W-1:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ncnt_q <= '0;
         lfsr_q <= LFSR_SEED;
      end else if (tick16) begin
         if (ncnt_q + 5'h01 >= nper) begin
            ncnt_q <= '0;
            lfsr_q <= {lfsr_q[0] ^ lfsr_q[3], lfsr_q[16:1]};
         end else begin
            ncnt_q <= ncnt_q + 5'h01;
         end
      end
   end

   a_noise_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !tick16 |=> $stable(lfsr_q))
      else $error("noise shifted between ticks");
   a_lfsr_alive: assert property (@(posedge pclk) disable iff (!presetn)
      lfsr_q != '0)
      else $error("noise register locked at zero");

   // ****************************************
   // Envelope generator
   // ****************************************
   logic [15:0] ecnt_q;
   logic [15:0] eper;
   logic [3:0] estep_q;
   logic eup_q;
   logic ehold_q;
   logic [7:0] shape;
   logic estep_tick;
   logic [3:0] env_level;
   assign eper = {regs_q[IDX_ENV_COARSE], regs_q[IDX_ENV_FINE]};
   assign shape = regs_q[IDX_ENV_SHAPE];
   assign estep_tick = tick256 && (ecnt_q + 16'h0001 >= eper);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ecnt_q <= '0;
      else if (env_restart) ecnt_q <= '0;
      else if (tick256) ecnt_q <= (ecnt_q + 16'h0001 >= eper) ? 16'h0000 : ecnt_q + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         estep_q <= '0;
         eup_q <= 1'b0;
         ehold_q <= 1'b1;
      end else if (env_restart) begin
         estep_q <= '0;
         eup_q <= pwdata[SHAPE_ATTACK];
         ehold_q <= 1'b0;
      end else if (estep_tick && !ehold_q) begin
         if (estep_q != 4'hf) begin
            estep_q <= estep_q + 4'h1;
         end else if (!shape[SHAPE_CONT]) begin
            ehold_q <= 1'b1;
            eup_q <= 1'b0;
         end else if (shape[SHAPE_HOLD]) begin
            ehold_q <= 1'b1;
            eup_q <= eup_q ^ shape[SHAPE_ALT];
         end else begin
            estep_q <= '0;
            eup_q <= eup_q ^ shape[SHAPE_ALT];
         end
      end
   end
   assign env_level = (ehold_q && !shape[SHAPE_CONT]) ? 4'h0 :
                      ehold_q ? (eup_q ? 4'hf : 4'h0) :
                      (eup_q ? estep_q : ~estep_q);

   a_env_still: assert property (@(posedge pclk) disable iff (!presetn)
      ehold_q && !env_restart |=> $stable(env_level))
      else $error("held envelope level moved");
   a_env_step: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(estep_q) |-> $past(estep_tick) || $past(env_restart))
      else $error("envelope stepped off its rate");
   a_env_oneshot: assert property (@(posedge pclk) disable iff (!presetn)
      ehold_q && !shape[SHAPE_CONT] |-> env_level == '0)
      else $error("single shot envelope not at zero");

   // ****************************************
   // Mixers and amplitude control
   // ****************************************
   logic [NUM_CH-1:0] mix;
   logic [LEVEL_W-1:0] lvl [NUM_CH];
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         mix[c] = (tone[c] | regs_q[IDX_MIXER][c]) &
                  (lfsr_q[0] | regs_q[IDX_MIXER][NOISE_EN_LSB + c]);
         lvl[c] = regs_q[int'(IDX_AMP_A) + c][AMP_MODE_BIT] ? env_level :
                  regs_q[int'(IDX_AMP_A) + c][LEVEL_W-1:0];
         if (!mix[c]) lvl[c] = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_a_q <= '0;
         level_b_q <= '0;
         level_c_q <= '0;
      end else begin
         level_a_q <= lvl[0];
         level_b_q <= lvl[1];
         level_c_q <= lvl[2];
      end
   end

   a_mix_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !mix[1] |=> level_b_q == '0)
      else $error("gated channel not silent");
   a_level_fixed: assert property (@(posedge pclk) disable iff (!presetn)
      mix[2] && !regs_q[int'(IDX_AMP_A) + 2][AMP_MODE_BIT] |=>
      level_c_q == $past(regs_q[int'(IDX_AMP_A) + 2][LEVEL_W-1:0]))
      else $error("fixed level not routed");
   a_noise_route: assert property (@(posedge pclk) disable iff (!presetn)
      regs_q[IDX_MIXER][0] && !regs_q[IDX_MIXER][NOISE_EN_LSB] |-> mix[0] == lfsr_q[0])
      else $error("noise not routed to mixer");
   a_tone_route: assert property (@(posedge pclk) disable iff (!presetn)
      !regs_q[IDX_MIXER][1] && regs_q[IDX_MIXER][NOISE_EN_LSB + 1] |-> mix[1] == tone[1])
      else $error("tone not routed to mixer");

   // ****************************************
   // Assertions
   // ****************************************
   a_write_stores: assert property (@(posedge pclk) disable iff (!presetn)
      acc && pwrite && mapped |=> regs_q[$past(idx)] == $past(pwdata[7:0]))
      else $error("register write not stored");
   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("apb answer not in one cycle");
   a_prescale_gap: assert property (@(posedge pclk) disable iff (!presetn)
      tick16 |=> !tick16 [*8])
      else $error("prescale tick too frequent");
   a_env_prescale: assert property (@(posedge pclk) disable iff (!presetn)
      tick256 |-> tick16)
      else $error("envelope prescale not aligned");
   a_tone_mute: assert property (@(posedge pclk) disable iff (!presetn)
      regs_q[IDX_MIXER][0] && regs_q[IDX_MIXER][NOISE_EN_LSB] &&
      !regs_q[IDX_AMP_A][AMP_MODE_BIT] |=> level_a_q == $past(regs_q[IDX_AMP_A][3:0]))
      else $error("disabled mixer changed level");
   a_env_select: assert property (@(posedge pclk) disable iff (!presetn)
      regs_q[IDX_AMP_A][AMP_MODE_BIT] && mix[0] |=> level_a_q == $past(env_level))
      else $error("envelope level not routed");
   a_env_restart: assert property (@(posedge pclk) disable iff (!presetn)
      env_restart |=> estep_q == 4'h0 && !ehold_q)
      else $error("envelope not restarted");
   a_tone_period: assert property (@(posedge pclk) disable iff (!presetn)
      g_tone[0].period[7:0] == regs_q[IDX_A_FINE])
      else $error("tone fine byte misrouted");
endmodule // sound_generator

// ==== test/apb_host.sv ====
`timescale 1ns/10ps
module apb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ****************************************
   // Host side register loads
   // ****************************************
   logic hung;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      hung = 1'b0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (pready !== 1'b1) hung = 1'b1;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // apb_host

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import sound_generator_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, t;
   logic [3:0] level_a_q, level_b_q, level_c_q, pv;
   int err_count, compares, c, n;
   sound_generator u_sound_generator (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .level_a_q(level_a_q), .level_b_q(level_b_q),
      .level_c_q(level_c_q));
   apb_host u_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] x, input logic [31:0] got);
      compares++;
      if (got !== x) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, x, got);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      u_apb_host.xfer(w, a, d, q, e);
      if (u_apb_host.hung) begin
         err_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [3:0] i, input logic [7:0] v);
      bus(1'b1, {6'h00, i, 2'b00}, {24'h000000, v});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      bus(1'b0, a, 32'h00000000);
      chk("prdata", x, q);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   function automatic logic [3:0] lvl(input int k);
      return (k == 0) ? level_a_q : (k == 1) ? level_b_q : level_c_q;
   endfunction
   task automatic per(input int k, output logic [31:0] p);
      int r;
      logic [3:0] o;
      r = 0;
      p = 32'h0;
      o = lvl(k);
      repeat (600) begin
         @(negedge pclk);
         if (r == 1) p = p + 32'h1;
         if (lvl(k) !== 4'h0 && o === 4'h0) r++;
         o = lvl(k);
         if (r == 2) break;
      end
   endtask
   task automatic gap(input int k, output logic [31:0] p);
      int r;
      logic [3:0] o;
      r = 0;
      p = 32'h0;
      o = lvl(k);
      repeat (2000) begin
         @(negedge pclk);
         if (r == 1) p = p + 32'h1;
         if (lvl(k) !== o) r++;
         o = lvl(k);
         if (r == 2) break;
      end
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      presetn = 1'b0;
      err_count = 0;
      compares = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      chk("level_a", 32'h0, {28'h0, level_a_q});
      rd(12'h000, 32'h000000ff, 1'b0);
      rd(12'h034, 32'h00000000, 1'b0);
      $display("test reset done");
      wr(IDX_A_FINE, 8'ha5);
      wr(IDX_ENV_FINE, 8'h5a);
      rd(12'h000, 32'h000000a5, 1'b0);
      rd(12'h02c, 32'h0000005a, 1'b0);
      rd(12'h040, 32'h00000000, 1'b1);
      rd(12'h001, 32'h00000000, 1'b1);
      $display("test bus done");
      wr(IDX_AMP_A, 8'he3);
      wr(4'h9, 8'h0a);
      wr(4'ha, 8'h0f);
      repeat (3) @(posedge pclk);
      chk("level_a", 32'h3, {28'h0, level_a_q});
      chk("level_b", 32'ha, {28'h0, level_b_q});
      chk("level_c", 32'hf, {28'h0, level_c_q});
      $display("test amplitude done");
      for (c = 0; c < 3; c++) begin
         wr(IDX_MIXER, ~(8'h01 << c));
         wr(4'(2 * c), 8'(c + 2));
         wr(4'(2 * c + 1), 8'hf0);
         per(c, t);
         chk("tone_period", 32'(16 * (c + 2)), t);
      end
      $display("test tone done");
      wr(IDX_NOISE_RATE, 8'he1);
      wr(IDX_MIXER, 8'hf7);
      n = 0;
      pv = level_a_q;
      repeat (2000) begin
         @(negedge pclk);
         if (level_a_q !== pv) n++;
         pv = level_a_q;
      end
      chk("noise_moves", 32'h1, {31'h0, n > 8});
      $display("test noise done");
      wr(IDX_MIXER, 8'hff);
      wr(IDX_ENV_FINE, 8'h01);
      wr(IDX_ENV_COARSE, 8'h00);
      wr(IDX_AMP_A, 8'h10);
      wr(IDX_ENV_SHAPE, 8'h0b);
      repeat (5000) @(posedge pclk);
      chk("env_top", 32'hf, {28'h0, level_a_q});
      repeat (600) @(posedge pclk);
      chk("env_hold", 32'hf, {28'h0, level_a_q});
      wr(IDX_ENV_SHAPE, 8'h00);
      repeat (5000) @(posedge pclk);
      chk("env_low", 32'h0, {28'h0, level_a_q});
      wr(IDX_ENV_SHAPE, 8'h0d);
      repeat (5000) @(posedge pclk);
      chk("env_alt", 32'hf, {28'h0, level_a_q});
      wr(IDX_ENV_FINE, 8'h02);
      wr(IDX_ENV_SHAPE, 8'h01);
      gap(0, t);
      chk("env_step", 32'(2 * ENV_PRESCALE), t);
      $display("test envelope done");
      close_out();
   end
endmodule // tb_top
